/* include/pwr_pkg.sv */
// Package of register offsets, field positions and types for the power-mode block.
package pwr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] clock_ctrl_reg0_off  = 12'h000;
  localparam logic [11:0] clock_ctrl_reg1_off  = 12'h004;
  localparam logic [11:0] protect_ctrl_reg_off = 12'h008;
  localparam logic [11:0] status_reg_off       = 12'h00c;
  localparam logic [11:0] port_out_reg_off     = 12'h010;
  localparam logic [11:0] port_dir_reg_off     = 12'h014;
  localparam logic [11:0] wo_reg_off           = 12'h018;
  localparam logic [11:0] rom_reg_off          = 12'h01c;
  localparam logic [11:0] osc_ctrl_reg_off     = 12'h020;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int wait_req_bit           = 0;  // clock_ctrl_reg0
  localparam int wait_periph_clock_stop = 2;  // clock_ctrl_reg0
  localparam int cpu_clk_sel_bit        = 7;  // clock_ctrl_reg0: 1 = sub clock
  localparam int stop_req_bit           = 0;  // clock_ctrl_reg1
  localparam int protect_unlock_bit2    = 2;  // protect_ctrl_reg
  localparam int main_drive_bit         = 0;  // osc_ctrl_reg: 1 = high drive
  localparam int sub_drive_bit          = 1;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [7:0]  clock_ctrl_reg0_rst = 8'h00;
  localparam logic [7:0]  osc_ctrl_reg_rst    = 8'h03;
  localparam logic [31:0] undefined_read      = 32'hdead_beef;
  localparam logic [31:0] rom_word            = 32'h5a5a_0001;  // Arbitrary value.
  localparam int          osc_settle_cycles   = 16;
  localparam logic [7:0]  wait_prefetch_cycles = 8'h04;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {run_st, wait_drain_st, wait_st, stop_st} power_state_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
  } port_state_t;

  typedef struct packed {
    logic main_stable;
    logic sub_stable;
  } osc_status_t;

endpackage : pwr_pkg

/* rtl/osc_settle.sv */
// Oscillator stabilisation counter for one oscillator.
module osc_settle
  import pwr_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      stable
);

  logic [7:0] count_reg;
  logic [7:0] count_next;

  // Counting restarts whenever the oscillator is halted.
  assign count_next = !run ? 8'h00 :
                      (count_reg == 8'(osc_settle_cycles)) ? count_reg : count_reg + 8'h01;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= 8'h00;
      stable    <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      stable    <= run && (count_next == 8'(osc_settle_cycles));
    end
  end

endmodule // osc_settle

/* rtl/power_mode_and_write_protect.sv */
// APB-controlled low-power mode, clock gating and write-protect block.

// Summary of operation
// (RULE1) Write-only register reads return undefined data
// (RULE2) Boot pin high at reset blocks ROM readout
// (RULE3) Host holds reset low until oscillator stable
// (RULE4) Timer wake needs pulse output select zero; code checks it only for wake from stop, wait wakes on wake_irq alone
// (RULE5) Prefetched instructions may run before wait entry
// (RULE6) Software adds short jump and four nops
// (RULE7) No RAM writes or DMA before wait
// (RULE8) Stop bit set enters stop mode
// (RULE9) Medium-speed resume uses sixteen-bit immediate write
// (RULE10) Switch clock source only after stabilisation
// (RULE11) Ports hold output and direction when halted
// (RULE12) Reference connected one microsecond before conversion
// (RULE13) Unused converter outputs disabled and zeroed
// (RULE14) Peripheral clock stops in wait except subclock
// (RULE15) Clear peripheral stop before slow wait entry
// (RULE16) Lower oscillator drive once stable
// (RULE17) Next write after unlock clears unlock bit
// (RULE18) Protected write immediately follows the unlock
// (RULE19) Stop halts oscillators; reset or wake resumes
module power_mode_and_write_protect
  import pwr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        boot_mode_pin,
  input  wire logic        wake_irq,
  input  wire logic        wake_pulse_output_select,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             subclock_divided_clk_en,
  output logic             main_osc_run,
  output logic             sub_osc_run,
  output logic             main_osc_drive_high,
  output logic             sub_osc_drive_high,
  output logic [7:0]       port_out,
  output logic [7:0]       port_dir
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] boot_sync_reg;
  logic [1:0] wake_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] boot_age_reg;
  logic       rom_lock_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_sync_reg <= 2'b00;
      wake_sync_reg <= 2'b00;
      sel_sync_reg  <= 2'b00;
    end
    else
    begin
      boot_sync_reg <= {boot_sync_reg[0], boot_mode_pin};
      wake_sync_reg <= {wake_sync_reg[0], wake_irq};
      sel_sync_reg  <= {sel_sync_reg[0], wake_pulse_output_select};
    end
  end

  // The strap is caught once, after it has crossed both synchroniser stages.
  // Until then the ROM stays locked, so an early read can never leak it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_age_reg <= 2'b00;
      rom_lock_reg <= 1'b1;
    end
    else if (boot_age_reg != 2'b11)
    begin
      boot_age_reg <= boot_age_reg + 2'b01;
      if (boot_age_reg == 2'b10)
        rom_lock_reg <= boot_sync_reg[1];  // [RULE2]
    end
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire access    = psel && penable;
  wire wr_strobe = access && pwrite;
  wire hit_cm0   = paddr == clock_ctrl_reg0_off;
  wire hit_cm1   = paddr == clock_ctrl_reg1_off;
  wire hit_prot  = paddr == protect_ctrl_reg_off;
  wire hit_stat  = paddr == status_reg_off;
  wire hit_pout  = paddr == port_out_reg_off;
  wire hit_pdir  = paddr == port_dir_reg_off;
  wire hit_wo    = paddr == wo_reg_off;
  wire hit_rom   = paddr == rom_reg_off;
  wire hit_osc   = paddr == osc_ctrl_reg_off;
  wire mapped    = hit_cm0 || hit_cm1 || hit_prot || hit_stat || hit_pout ||
                   hit_pdir || hit_wo || hit_rom || hit_osc;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]   cm0_reg;
  logic         unlock_reg;
  logic [7:0]   wo_reg;
  logic [7:0]   osc_reg;
  port_state_t  port_reg;
  power_state_t state_reg;
  power_state_t state_next;
  logic [7:0]   drain_reg;
  osc_status_t  osc_stat;

  wire halted      = state_reg == wait_st || state_reg == stop_st;
  // Writing a protected register consumes the unlock.
  wire prot_ok     = unlock_reg;
  wire stop_write  = wr_strobe && hit_cm1 && prot_ok && pwdata[stop_req_bit];
  wire wait_write  = wr_strobe && hit_cm0 && pwdata[wait_req_bit];
  wire wake_ok     = wake_sync_reg[1] && !sel_sync_reg[1];  // [RULE4]
  wire want_sub    = cm0_reg[cpu_clk_sel_bit];
  wire sel_ready   = want_sub ? osc_stat.sub_stable : osc_stat.main_stable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cm0_reg    <= clock_ctrl_reg0_rst;
      unlock_reg <= 1'b0;
      wo_reg     <= 8'h00;
      osc_reg    <= osc_ctrl_reg_rst;
      port_reg   <= '0;
    end
    else if (wr_strobe)
    begin
      if (hit_cm0)
        cm0_reg <= pwdata[7:0] & ~(8'h01 << wait_req_bit);
      if (hit_wo)
        wo_reg <= pwdata[7:0];
      if (hit_osc)
        osc_reg <= pwdata[7:0];  // [RULE16]
      if (hit_pout && !halted)
        port_reg.out <= pwdata[7:0];  // [RULE11]
      if (hit_pdir && !halted)
        port_reg.dir <= pwdata[7:0];  // [RULE11]
      // Any write other than to the unlock register itself relocks.
      unlock_reg <= hit_prot ? pwdata[protect_unlock_bit2] : 1'b0;  // [RULE17]
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      run_st:        if (stop_write) state_next = stop_st;  // [RULE8]
                     else if (wait_write) state_next = wait_drain_st;
      // Queued instructions still run for a few cycles before the halt.
      wait_drain_st: if (drain_reg == wait_prefetch_cycles) state_next = wait_st;  // [RULE5]
      wait_st:       if (wake_sync_reg[1]) state_next = run_st;
      stop_st:       if (wake_ok) state_next = run_st;  // [RULE19]
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= run_st;
      drain_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      drain_reg <= (state_reg == wait_drain_st) ? drain_reg + 8'h01 : 8'h00;
    end
  end

  osc_settle main_settle (.pclk(pclk), .presetn(presetn), .run(state_reg != stop_st),
                          .stable(osc_stat.main_stable));
  osc_settle sub_settle  (.pclk(pclk), .presetn(presetn), .run(state_reg != stop_st),
                          .stable(osc_stat.sub_stable));

  // ****************************************************************
  // Outputs and read data
  // ****************************************************************
  wire [31:0] stat_word = {27'h0, rom_lock_reg, osc_stat.main_stable, osc_stat.sub_stable,
                           state_reg};
  wire [31:0] rd_mux =
    hit_cm0  ? {24'h0, cm0_reg} :
    hit_prot ? {29'h0, unlock_reg, 2'b00} :
    hit_stat ? stat_word :
    hit_pout ? {24'h0, port_reg.out} :
    hit_pdir ? {24'h0, port_reg.dir} :
    hit_osc  ? {24'h0, osc_reg} :
    hit_rom  ? (rom_lock_reg ? 32'h0 : rom_word) :  // [RULE2]
    undefined_read;  // [RULE1]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata                  <= 32'h0;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      cpu_clk_en              <= 1'b1;
      periph_clk_en           <= 1'b1;
      subclock_divided_clk_en <= 1'b1;
      main_osc_run            <= 1'b1;
      sub_osc_run             <= 1'b1;
      main_osc_drive_high     <= 1'b1;
      sub_osc_drive_high      <= 1'b1;
      port_out                <= 8'h00;
      port_dir                <= 8'h00;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      cpu_clk_en    <= !halted && sel_ready;  // [RULE10]
      periph_clk_en <= state_reg == stop_st ? 1'b0 :
                       !(state_reg == wait_st && cm0_reg[wait_periph_clock_stop]);  // [RULE14]
      subclock_divided_clk_en <= state_reg != stop_st;  // [RULE14]
      main_osc_run  <= state_reg != stop_st;  // [RULE19]
      sub_osc_run   <= state_reg != stop_st;
      main_osc_drive_high <= osc_reg[main_drive_bit];
      sub_osc_drive_high  <= osc_reg[sub_drive_bit];
      port_out <= port_reg.out;
      port_dir <= port_reg.dir;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence relocking_write;
    unlock_reg && wr_strobe && !hit_prot;
  endsequence

  unlock_relock_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE17]
    relocking_write |=> !unlock_reg)
    else $error("Unlock bit not cleared by next write.");

  stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE8]
    state_reg == run_st && stop_write |=> state_reg == stop_st ##1 !main_osc_run)
    else $error("Stop write did not enter stop mode.");

  stop_osc_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE19]
    state_reg == stop_st && $past(state_reg) == stop_st |-> !main_osc_run && !sub_osc_run)
    else $error("Oscillator running in stop mode.");

  port_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE11]
    halted && $past(halted) |=> $stable(port_out) && $stable(port_dir))
    else $error("Port state changed while halted.");

  periph_gate_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE14]
    state_reg == wait_st && cm0_reg[wait_periph_clock_stop] |=>
      !periph_clk_en && subclock_divided_clk_en)
    else $error("Peripheral clock gating wrong in wait.");

  wait_drain_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE5]
    state_reg == run_st && wait_write && !stop_write |=>
      (state_reg == wait_drain_st) [*5] ##1 state_reg == wait_st)
    else $error("Wait entry drain length wrong.");

  rom_block_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE2]
    psel && !penable && !pwrite && hit_rom && rom_lock_reg |=> prdata == 32'h0)
    else $error("ROM readable while locked.");

  wo_read_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE1]
    psel && !penable && !pwrite && hit_wo |=> prdata == undefined_read)
    else $error("Write-only register read returned data.");

  clk_sel_a: assert property (@(posedge pclk) disable iff (!presetn)  // [RULE10]
    !sel_ready |=> !cpu_clk_en)
    else $error("CPU clock ran on unstable source.");

endmodule // power_mode_and_write_protect

/* verification/power_mode_and_write_protect_tb_top.sv */
// Self-checking testbench for the power-mode and write-protect block.
module power_mode_and_write_protect_tb_top;
  import pwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, boot_mode_pin, wake_irq, wake_pulse_output_select;
  logic        cpu_clk_en, periph_clk_en, subclock_divided_clk_en, main_osc_run, sub_osc_run;
  logic        main_osc_drive_high, sub_osc_drive_high;
  logic [7:0]  port_out, port_dir;
  int          n_fail, num_checks, cycles;

  power_mode_and_write_protect DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_mode_pin(boot_mode_pin), .wake_irq(wake_irq),
    .wake_pulse_output_select(wake_pulse_output_select), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .subclock_divided_clk_en(subclock_divided_clk_en),
    .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run),
    .main_osc_drive_high(main_osc_drive_high), .sub_osc_drive_high(sub_osc_drive_high),
    .port_out(port_out), .port_dir(port_dir)
  );

  // ****************************************************************
  // Clock, timeout and report
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // The whole run needs a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0t timeout", $time);
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Compare and bus tasks
  // ****************************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the bench timeout ends a hung transfer.
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk_word(rd, exp);
    chk_bit(err, exp_err);
  endtask

  task automatic wait_for(ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk_bit(sig, val);
  endtask

  task automatic do_reset(input logic boot);
    boot_mode_pin <= boot;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // The clock enable only drops one edge after release, so let it fall first.
    repeat (2) @(posedge pclk);
    wait_for(cpu_clk_en, 1'b1);
    repeat (4) @(posedge pclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd_chk(status_reg_off, 32'h0000_000c, 1'b0);
    rd_chk(osc_ctrl_reg_off, {24'h0, osc_ctrl_reg_rst}, 1'b0);
    rd_chk(clock_ctrl_reg0_off, {24'h0, clock_ctrl_reg0_rst}, 1'b0);
    rd_chk(wo_reg_off, undefined_read, 1'b0);
    rd_chk(clock_ctrl_reg1_off, undefined_read, 1'b0);
    rd_chk(12'h100, undefined_read, 1'b1);
    rd_chk(rom_reg_off, rom_word, 1'b0);
    wr(osc_ctrl_reg_off, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk_bit(main_osc_drive_high, 1'b0);
    chk_bit(sub_osc_drive_high, 1'b0);
  endtask

  task automatic t_boot_lock();
    do_reset(1'b1);
    rd_chk(rom_reg_off, 32'h0000_0000, 1'b0);
    rd_chk(status_reg_off, 32'h0000_001c, 1'b0);
    do_reset(1'b0);
  endtask

  task automatic t_protect();
    wr(clock_ctrl_reg1_off, 32'h0000_0001);
    rd_chk(status_reg_off, 32'h0000_000c, 1'b0);
    wr(protect_ctrl_reg_off, 32'h0000_0004);
    wr(port_dir_reg_off, 32'h0000_003c);
    wr(clock_ctrl_reg1_off, 32'h0000_0001);
    rd_chk(status_reg_off, 32'h0000_000c, 1'b0);
    chk_word({24'h0, port_dir}, 32'h0000_003c);
  endtask

  task automatic t_wait(input logic stop_periph);
    wr(port_out_reg_off, 32'h0000_00a5);
    wr(clock_ctrl_reg0_off, {29'h0, stop_periph, 2'b01});
    @(posedge pclk);
    chk_bit(cpu_clk_en, 1'b1);
    repeat (10) @(posedge pclk);
    chk_bit(cpu_clk_en, 1'b0);
    chk_bit(periph_clk_en, ~stop_periph);
    chk_bit(subclock_divided_clk_en, 1'b1);
    rd_chk(status_reg_off, 32'h0000_000e, 1'b0);
    wr(port_out_reg_off, 32'h0000_005a);
    chk_word({24'h0, port_out}, 32'h0000_00a5);
    wake_irq <= 1'b1;
    wait_for(cpu_clk_en, 1'b1);
    wake_irq <= 1'b0;
    chk_bit(periph_clk_en, 1'b1);
    rd_chk(clock_ctrl_reg0_off, {29'h0, stop_periph, 2'b00}, 1'b0);
  endtask

  task automatic t_stop();
    wr(protect_ctrl_reg_off, 32'h0000_0004);
    wr(clock_ctrl_reg1_off, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    chk_bit(main_osc_run, 1'b0);
    chk_bit(sub_osc_run, 1'b0);
    chk_bit(subclock_divided_clk_en, 1'b0);
    chk_bit(cpu_clk_en, 1'b0);
    wr(port_dir_reg_off, 32'h0000_00ff);
    chk_word({16'h0, port_out, port_dir}, 32'h0000_a53c);
    wake_pulse_output_select <= 1'b1;
    wake_irq <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_bit(main_osc_run, 1'b0);
    wake_pulse_output_select <= 1'b0;
    wait_for(main_osc_run, 1'b1);
    wake_irq <= 1'b0;
    wait_for(cpu_clk_en, 1'b1);
    rd_chk(status_reg_off, 32'h0000_000c, 1'b0);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    boot_mode_pin = 1'b0;
    wake_irq = 1'b0;
    wake_pulse_output_select = 1'b0;
    do_reset(1'b0);
    t_regs();
    t_boot_lock();
    t_protect();
    t_wait(1'b1);
    t_wait(1'b0);
    t_stop();
    results();
  end

endmodule // power_mode_and_write_protect_tb_top
